// File: inc/swsp_pkg.sv
// Behaviour
// - timeout sets periodic wake flag bit 7
// - ack bit 6 write 1 clears flag
// - clock select picks 1 kHz or 32 kHz/32
// - bit 4 enables periodic wake interrupt
// - delay select bits 2:0 pick timeout
// - timeout counts 1 ms ticks
// - oscillator off in stop when 000 and select
// - detect event sets undervolt flag when enabled
// - undervolt ack bit 6 clears flag
// - irq enable bit 5 requests interrupt on flag
// - write-once reset enable forces system reset
// - stop enable keeps detection in stop
// - detector enable bit 2 gates detector bits
// - bit 0 enables reference buffer
// - write-once bits take first write only
// - pending bit 4 is keypad flag and enable
// - pending bit 3 is comparator flag and enable
// - pending bit 2 is overflow flag and enable
// - pending bit 1 is wake flag and enable
// - pending bit 0 undervolt flag, enables
// - reset clears pending summary
package swsp_pkg;
    localparam logic [1:0] SWSP_ADDR_WAKE    = 2'h0;
    localparam logic [1:0] SWSP_ADDR_SUPPLY  = 2'h1;
    localparam logic [1:0] SWSP_ADDR_PENDING = 2'h2;
    localparam int SWSP_FLAG_BIT   = 7;
    localparam int SWSP_ACK_BIT    = 6;
    localparam int SWSP_CLKS_BIT   = 5;
    localparam int SWSP_PERIODIC_IRQ_ENABLE_BIT   = 4;
    localparam int SWSP_UVIE_BIT   = 5;
    localparam int SWSP_UVRE_BIT   = 4;
    localparam int SWSP_UVSE_BIT   = 3;
    localparam int SWSP_DETE_BIT   = 2;
    localparam int SWSP_REFB_BIT   = 0;
    localparam int SWSP_PEND_KEY   = 4;
    localparam int SWSP_PEND_CMP   = 3;
    localparam int SWSP_PEND_TMR   = 2;
    localparam int SWSP_PEND_WAKE  = 1;
    localparam int SWSP_PEND_UV    = 0;
    localparam logic [2:0] SWSP_SEL_OFF = 3'h0;
    localparam logic [4:0] SWSP_FAST_DIV = 5'h1f; // 32 kHz edges per ms, minus 1
    // last 1 ms tick index of each period
    localparam logic [9:0] SWSP_LAST_8MS    = 10'h007;
    localparam logic [9:0] SWSP_LAST_32MS   = 10'h01f;
    localparam logic [9:0] SWSP_LAST_64MS   = 10'h03f;
    localparam logic [9:0] SWSP_LAST_128MS  = 10'h07f;
    localparam logic [9:0] SWSP_LAST_256MS  = 10'h0ff;
    localparam logic [9:0] SWSP_LAST_512MS  = 10'h1ff;
    localparam logic [9:0] SWSP_LAST_1024MS = 10'h3ff;
    localparam logic [7:0] SWSP_WAKE_RESET   = 8'h00;
    localparam logic [7:0] SWSP_SUPPLY_RESET = 8'h00;
    localparam logic [7:0] SWSP_ZERO         = 8'h00;
    localparam logic [7:0] SWSP_WAKE_RMASK   = 8'hbf;
    localparam logic [7:0] SWSP_SUPPLY_RMASK = 8'hbd;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } swsp_bus_t;

    typedef struct packed {
        logic       keypad_flag;
        logic       keypad_irq_enable;
        logic       comparator_flag;
        logic       comparator_irq_enable;
        logic       timer_overflow_flag;
        logic       timer_overflow_irq_enable;
    } swsp_periph_t;

    typedef struct packed {
        logic       clk_slow;
        logic       clk_fast;
        logic       uv_detect;
        logic       stop_mode;
    } swsp_sync_t;

    typedef struct packed {
        swsp_sync_t  s1;
        swsp_sync_t  s2;
        logic        slow_d;
        logic        fast_d;
        logic [4:0]  fast_div;
        logic [9:0]  ms_count;
        logic        periodic_wake_flag;
        logic        periodic_clock_select;
        logic        periodic_irq_enable;
        logic [2:0]  periodic_delay_select;
        logic        undervolt_flag;
        logic        undervolt_irq_enable;
        logic        undervolt_reset_enable;
        logic        undervolt_stop_enable;
        logic        detector_enable;
        logic        ref_buffer_enable;
        logic        once_done;
        logic [7:0]  pending;
        logic [7:0]  rdata;
    } swsp_state_t;
endpackage

// File: src/swsp_regs.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module swsp_regs
    import swsp_pkg::*;
(
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // register port
    input  wire swsp_bus_t    bus_in,
    output logic [7:0]        rdata_out,
    // outside clocks, detector and stop mode, asynchronous
    input  wire logic         osc_1khz_in,
    input  wire logic         osc_32khz_in,
    input  wire logic         uv_detect_in,
    input  wire logic         stop_mode_in,
    // flags of neighbouring modules, same clock
    input  wire swsp_periph_t periph_in,
    // controls out
    output logic              periodic_irq_out,
    output logic              undervolt_irq_out,
    output logic              undervolt_reset_out,
    output logic              detector_on_out,
    output logic              ref_buffer_on_out,
    output logic              osc_1khz_off_out
);
    swsp_state_t st;
    swsp_state_t next_st;

    function automatic logic [9:0] swsp_period(input logic [2:0] sel);
        case (sel)
            3'h1:    swsp_period = SWSP_LAST_8MS;
            3'h2:    swsp_period = SWSP_LAST_32MS;
            3'h3:    swsp_period = SWSP_LAST_64MS;
            3'h4:    swsp_period = SWSP_LAST_128MS;
            3'h5:    swsp_period = SWSP_LAST_256MS;
            3'h6:    swsp_period = SWSP_LAST_512MS;
            3'h7:    swsp_period = SWSP_LAST_1024MS;
            default: swsp_period = 10'h000;
        endcase
    endfunction

    logic       tick;
    logic       timeout;
    logic       uv_active;
    logic       wr_wake;
    logic       wr_supply;
    logic [9:0] last;
    swsp_sync_t raw;

    always_comb begin
        raw = '{clk_slow: osc_1khz_in, clk_fast: osc_32khz_in,
                uv_detect: uv_detect_in, stop_mode: stop_mode_in};
        next_st = st;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.slow_d = st.s2.clk_slow;
        next_st.fast_d = st.s2.clk_fast;
        wr_wake   = bus_in.wr && bus_in.addr[1:0] == SWSP_ADDR_WAKE;
        wr_supply = bus_in.wr && bus_in.addr[1:0] == SWSP_ADDR_SUPPLY;
        // 1 ms tick source
        tick = 1'b0;
        if (st.periodic_clock_select) begin
            if (st.s2.clk_fast && !st.fast_d) begin
                next_st.fast_div = st.fast_div + 5'h01;
                tick = st.fast_div == SWSP_FAST_DIV;
            end
        end else begin
            next_st.fast_div = 5'h00;
            tick = st.s2.clk_slow && !st.slow_d;
        end
        last = swsp_period(st.periodic_delay_select);
        timeout = 1'b0;
        if (st.periodic_delay_select == SWSP_SEL_OFF) begin
            next_st.ms_count = 10'h000;
        end else if (tick) begin
            if (st.ms_count >= last) begin
                next_st.ms_count = 10'h000;
                timeout = 1'b1;
            end else begin
                next_st.ms_count = st.ms_count + 10'h001;
            end
        end
        // wake flag: set wins over ack
        if (wr_wake && bus_in.wdata[SWSP_ACK_BIT])
            next_st.periodic_wake_flag = 1'b0;
        if (timeout)
            next_st.periodic_wake_flag = 1'b1;
        if (wr_wake) begin
            next_st.periodic_clock_select = bus_in.wdata[SWSP_CLKS_BIT];
            next_st.periodic_irq_enable = bus_in.wdata[SWSP_PERIODIC_IRQ_ENABLE_BIT];
            next_st.periodic_delay_select = bus_in.wdata[2:0];
        end
        // undervolt detector
        uv_active = st.detector_enable &&
                    (!st.s2.stop_mode || st.undervolt_stop_enable);
        if (wr_supply) begin
            next_st.undervolt_irq_enable = bus_in.wdata[SWSP_UVIE_BIT];
            next_st.undervolt_stop_enable = bus_in.wdata[SWSP_UVSE_BIT];
            next_st.ref_buffer_enable = bus_in.wdata[SWSP_REFB_BIT];
            if (!st.once_done) begin
                next_st.once_done = 1'b1;
                next_st.undervolt_reset_enable = bus_in.wdata[SWSP_UVRE_BIT];
                next_st.detector_enable = bus_in.wdata[SWSP_DETE_BIT];
            end
            if (bus_in.wdata[SWSP_ACK_BIT])
                next_st.undervolt_flag = 1'b0;
        end
        if (uv_active && st.s2.uv_detect)
            next_st.undervolt_flag = 1'b1;
        // pending summary from next values
        next_st.pending = SWSP_ZERO;
        next_st.pending[SWSP_PEND_KEY] = periph_in.keypad_flag &&
            periph_in.keypad_irq_enable;
        next_st.pending[SWSP_PEND_CMP] = periph_in.comparator_flag &&
            periph_in.comparator_irq_enable;
        next_st.pending[SWSP_PEND_TMR] = periph_in.timer_overflow_flag &&
            periph_in.timer_overflow_irq_enable;
        next_st.pending[SWSP_PEND_WAKE] = next_st.periodic_wake_flag &&
            next_st.periodic_irq_enable;
        next_st.pending[SWSP_PEND_UV] = next_st.undervolt_flag &&
            next_st.undervolt_irq_enable && next_st.detector_enable;
        // read data
        next_st.rdata = SWSP_ZERO;
        if (bus_in.rd) begin
            case (bus_in.addr[1:0])
                SWSP_ADDR_WAKE: next_st.rdata = SWSP_WAKE_RMASK &
                    {st.periodic_wake_flag, 1'b0, st.periodic_clock_select,
                     st.periodic_irq_enable, 1'b0,
                     st.periodic_delay_select};
                SWSP_ADDR_SUPPLY: next_st.rdata = SWSP_SUPPLY_RMASK &
                    {st.undervolt_flag, 1'b0, st.undervolt_irq_enable,
                     st.undervolt_reset_enable, st.undervolt_stop_enable,
                     st.detector_enable, 1'b0, st.ref_buffer_enable};
                SWSP_ADDR_PENDING: next_st.rdata = st.pending;
                default: next_st.rdata = SWSP_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out = st.rdata;
    assign periodic_irq_out = st.pending[SWSP_PEND_WAKE];
    assign undervolt_irq_out = st.pending[SWSP_PEND_UV];
    assign undervolt_reset_out = st.undervolt_flag &&
        st.undervolt_reset_enable && st.detector_enable;
    assign detector_on_out = st.detector_enable &&
        (!st.s2.stop_mode || st.undervolt_stop_enable);
    assign ref_buffer_on_out = st.ref_buffer_enable;
    assign osc_1khz_off_out = st.s2.stop_mode &&
        st.periodic_delay_select == SWSP_SEL_OFF &&
        st.periodic_clock_select;
endmodule
`default_nettype wire

// File: tb/swsp_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module swsp_regs_checker
    import swsp_pkg::*;
(
    // watched ports
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire swsp_bus_t  bus_in,
    input  wire logic [7:0] rdata_out,
    input  wire logic       stop_mode_in,
    input  wire logic       periodic_irq_out,
    input  wire logic       ref_buffer_on_out,
    input  wire logic       osc_1khz_off_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic w0 = bus_in.wr && bus_in.addr[1:0] == 2'h0;
    wire logic w1 = bus_in.wr && bus_in.addr[1:0] == 2'h1;
    wire logic r_pend = bus_in.rd && bus_in.addr[1:0] == 2'h2;
    ref_load_a: assert property (w1 |=>
        ref_buffer_on_out == $past(bus_in.wdata[0])) else $error("ref load");
    ref_cause_a: assert property ($changed(ref_buffer_on_out)
        |-> $past(w1)) else $error("ref changed without write");
    rdata_idle_a: assert property (!bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data without read");
    ack_reads_a: assert property (bus_in.rd && !bus_in.addr[1]
        |=> !rdata_out[6]) else $error("ack bit read as one");
    pend_upper_a: assert property (r_pend |=> rdata_out[7:5] == 3'h0)
        else $error("pending upper bits set");
    unmapped_zero_a: assert property (bus_in.rd &&
        bus_in.addr[1:0] == 2'h3 |=> rdata_out == 8'h00)
        else $error("unmapped read");
    osc_stop_a: assert property (!stop_mode_in [*4] |=>
        !osc_1khz_off_out) else $error("oscillator off outside stop");
    wake_drop_a: assert property (w0 && (bus_in.wdata[6] ||
        !bus_in.wdata[4]) |=> !periodic_irq_out) else $error("wake irq");
    cover property (periodic_irq_out);
    cover property (w1);
    cover property (osc_1khz_off_out);
endmodule
`default_nettype wire

// File: tb/swsp_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module swsp_regs_bench
    import swsp_pkg::*;
;
    logic clk_in = 1'b0, reset_n_in = 1'b0, osc1 = 1'b0, osc32 = 1'b0;
    logic uvd = 1'b0, stop = 1'b0, rd_d = 1'b0;
    logic [7:0] cnt = 8'h00;
    swsp_bus_t bus = '0;
    swsp_periph_t per = '0;
    logic [7:0] rdata, exp_q[$];
    logic irq_w, irq_uv, rst_uv, det_on, ref_on, osc_off;
    int num_errors = 0, num_checks = 0, seed = 47, n;
    always #2 clk_in = ~clk_in;
    swsp_regs swsp_regs_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .bus_in(bus), .rdata_out(rdata), .osc_1khz_in(osc1),
        .osc_32khz_in(osc32), .uv_detect_in(uvd), .stop_mode_in(stop),
        .periph_in(per), .periodic_irq_out(irq_w),
        .undervolt_irq_out(irq_uv), .undervolt_reset_out(rst_uv),
        .detector_on_out(det_on), .ref_buffer_on_out(ref_on),
        .osc_1khz_off_out(osc_off));
    // fast stand-ins: 1 ms is 32 or 32x4 cycles
    always @(posedge clk_in) begin
        cnt <= cnt + 8'h01;
        osc1 <= cnt[4];
        osc32 <= cnt[1];
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        bus <= '0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_in);
        bus <= '0;
        @(posedge clk_in);
    endtask
    task automatic wait_wake(input int lo, hi);
        n = 0;
        while (irq_w !== 1'b1 && n < hi) begin
            @(posedge clk_in);
            n++;
        end
        chk("wake delay", 8'(n >= lo && n < hi), 8'h01);
        if (n >= hi)
            tally_and_finish();
    endtask
    // read data stands only in the cycle after the read
    always @(posedge clk_in) begin
        if (rd_d)
            chk("rdata", rdata, exp_q.pop_front());
        rd_d <= bus.rd;
    end
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
        rd(8'h03, 8'h00);
        for (int i = 0; i < 8; i++) begin
            per <= 6'($random(seed));
            repeat (3) @(posedge clk_in);
            rd(8'h02, {3'h0, per[5] & per[4], per[3] & per[2],
                per[1] & per[0], 2'h0});
        end
        per <= '0;
        wr(8'h00, 8'h11);
        rd(8'h00, 8'h11);
        wait_wake(220, 270);
        rd(8'h00, 8'h91);
        rd(8'h02, 8'h02);
        wr(8'h00, 8'h51);
        rd(8'h00, 8'h11);
        rd(8'h02, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h31);
        wait_wake(880, 1040);
        wr(8'h00, 8'h60);
        stop <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("osc off", {7'h0, osc_off}, 8'h01);
        stop <= 1'b0;
        repeat (300) @(posedge clk_in);
        rd(8'h00, 8'h20);
        uvd <= 1'b1;
        repeat (4) @(posedge clk_in);
        rd(8'h01, 8'h00);
        wr(8'h01, 8'h25);
        repeat (4) @(posedge clk_in);
        rd(8'h01, 8'ha5);
        rd(8'h02, 8'h01);
        chk("uv irq", {7'h0, irq_uv}, 8'h01);
        chk("ref on", {7'h0, ref_on}, 8'h01);
        uvd <= 1'b0;
        repeat (4) @(posedge clk_in);
        wr(8'h01, 8'h59);
        rd(8'h01, 8'h0d);
        stop <= 1'b1;
        uvd <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("detector on", {7'h0, det_on}, 8'h01);
        chk("uv reset", {7'h0, rst_uv}, 8'h00);
        chk("uv irq", {7'h0, irq_uv}, 8'h00);
        reset_n_in <= 1'b0;
        stop <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        wr(8'h01, 8'h14);
        repeat (4) @(posedge clk_in);
        chk("uv reset", {7'h0, rst_uv}, 8'h01);
        stop <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("detector off", {7'h0, det_on}, 8'h00);
        tally_and_finish();
    end
endmodule
bind swsp_regs swsp_regs_checker swsp_regs_checker_i (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .stop_mode_in(stop_mode_in), .periodic_irq_out(periodic_irq_out),
    .ref_buffer_on_out(ref_buffer_on_out),
    .osc_1khz_off_out(osc_1khz_off_out));
`default_nettype wire
